// *** core/hfs_map.vh ***
// Register numbers, field positions, factor codes and resets of the handwheel factor select block.
// Included by the design files. Holds definitions only.
`ifndef HFS_MAP_VH
`define HFS_MAP_VH

// ----------------------------------------------------------------
// Register numbers on the variable port
// ----------------------------------------------------------------
`define HFS_REG_WHEEL1_COUNT 4'h0
`define HFS_REG_WHEEL2_COUNT 4'h1
`define HFS_REG_WHEEL3_COUNT 4'h2
`define HFS_REG_WHEEL4_COUNT 4'h3
`define HFS_REG_BUTTON 4'h4
`define HFS_REG_MULT_SELECT 4'h5
`define HFS_REG_PRIORITY_CTRL 4'h6
`define HFS_REG_LINE_ANGLE 4'h7
`define HFS_REG_ARC_CENTRE_1 4'h8
`define HFS_REG_ARC_CENTRE_2 4'h9

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define HFS_AXES 9
`define HFS_FIELD_W 3
`define HFS_AXIS_BITS 27
`define HFS_PRIO_BIT 27
`define HFS_ENABLE_BIT 28

// ----------------------------------------------------------------
// Factor codes and resets
// ----------------------------------------------------------------
`define HFS_FACT_PANEL 2'h0
`define HFS_FACT_X1 2'h1
`define HFS_FACT_X10 2'h2
`define HFS_FACT_X100 2'h3
`define HFS_RST_WORD 32'h00000000
`define HFS_SYNC_RST 3'h0

`endif

// *** core/hfs_field_decode.v ***
// One axis field decoder: three select bits to a factor code.
// Pure combinational; used twice per axis by the top module, once for each of the multiplier and priority words.
`timescale 1ns/1ps
`default_nettype none
`include "hfs_map.vh"

module hfs_field_decode (
   input wire [2:0] i_field,   // c b a bits of one axis
   output reg [1:0] o_factor,  // factor code
   output wire o_selected      // any bit set
);
   assign o_selected = |i_field;

   // ----------------------------------------------------------------
   // Lowest set bit wins
   // ----------------------------------------------------------------
   always @* begin
      if (i_field[0]) begin
         o_factor = `HFS_FACT_X1; // RULE4 RULE5
      end else if (i_field[1]) begin
         o_factor = `HFS_FACT_X10; // RULE4 RULE5
      end else if (i_field[2]) begin
         o_factor = `HFS_FACT_X100; // RULE4
      end else begin
         o_factor = `HFS_FACT_PANEL; // RULE4
      end
   end
endmodule // hfs_field_decode

`default_nettype wire

// *** core/hfs_top.v ***
// Handwheel factor select: pulse counters, axis button, factor and priority handling.
// Pulses and button come from pins; the program reaches words by register number.
// Behaviour
// RULE1 - Four readable pulse counts since reset
// RULE2 - Readable axis button status, zero unpressed
// RULE3 - Nine 3-bit axis fields, X at lsb
// RULE4 - Field: 000 panel, a x1, b x10, c x100
// RULE5 - Several bits set: lowest set bit wins
// RULE6 - Sample factors on entering handwheel position
// RULE7 - Enable flag set uses priority wheel pulses
// RULE8 - Priority flag picks individual or general wheel
// RULE9 - Several axes: only highest priority moves; code holds only general wheel pulses to it, individual wheels move any axis
// RULE10 - Nonzero priority word forces handwheel mode
// RULE11 - Program supplies path angle and arc centre
`timescale 1ns/1ps
`default_nettype none
`include "hfs_map.vh"

module hfs_top (
   input wire i_clk,                 // 125 MHz clock
   input wire i_sys_rst,             // sync reset, high
   input wire [3:0] i_wheel_pulse,   // wheel pulse pins, 1..4
   input wire [3:0] i_wheel_dir,     // wheel direction pins, 1 = down
   input wire i_axis_button,         // axis selector button pin
   input wire i_prio_pulse,          // priority wheel pulse pin
   input wire i_prio_dir,            // priority wheel direction pin
   input wire [8:0] i_indiv_pulse,   // individual per-axis wheel pulses
   input wire [8:0] i_indiv_dir,     // individual per-axis directions
   input wire i_switch_wheel,        // mode switch in handwheel position
   input wire [1:0] i_panel_factor,  // front-panel factor code
   input wire i_wr,                  // register write strobe
   input wire [3:0] i_addr,          // register number
   input wire [31:0] i_wdata,        // write data
   output reg [31:0] o_rdata,        // read data
   output reg o_wheel_mode,          // handwheel mode active
   output reg [17:0] o_axis_factor,  // applied factor per axis
   output reg [8:0] o_axis_step,     // per-axis move pulse
   output reg [8:0] o_axis_dir,      // per-axis move direction
   output reg [31:0] o_line_angle,   // path line angle
   output reg [31:0] o_arc_centre_1, // arc centre first coordinate
   output reg [31:0] o_arc_centre_2  // arc centre second coordinate
);

   // ----------------------------------------------------------------
   // Pin synchronisers, three stages
   // ----------------------------------------------------------------
   // Three stages cost a cycle of latency but keep slow pin edges clean
   localparam NPIN = 29;
   wire [NPIN-1:0] pin_raw;
   reg [NPIN-1:0] sync1;
   reg [NPIN-1:0] sync2;
   reg [NPIN-1:0] sync3;
   reg [NPIN-1:0] pin_ok;
   reg [NPIN-1:0] pin_ok_d;
   // Packing order fixes the tap positions below
   assign pin_raw = {
      i_indiv_dir,   // 28:20
      i_indiv_pulse, // 19:11
      i_prio_dir,    // 10
      i_prio_pulse,  // 9
      i_axis_button, // 8
      i_wheel_dir,   // 7:4
      i_wheel_pulse  // 3:0
   };

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         sync1 <= {NPIN{1'b0}};
         sync2 <= {NPIN{1'b0}};
         sync3 <= {NPIN{1'b0}};
         pin_ok <= {NPIN{1'b0}};
         pin_ok_d <= {NPIN{1'b0}};
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         // Accept a change only when stages two and three agree
         pin_ok <= (sync2 & sync3) | (pin_ok & (sync2 | sync3));
         pin_ok_d <= pin_ok;
      end
   end

   wire [3:0] wheel_edge = pin_ok[3:0] & ~pin_ok_d[3:0];
   wire [3:0] wheel_dn = pin_ok[7:4];
   wire button_lvl = pin_ok[8];
   wire prio_edge = pin_ok[9] & ~pin_ok_d[9];
   wire prio_dn = pin_ok[10];
   wire [8:0] indiv_edge = pin_ok[19:11] & ~pin_ok_d[19:11];
   wire [8:0] indiv_dn = pin_ok[28:20];

   // ----------------------------------------------------------------
   // Pulse counters
   // ----------------------------------------------------------------
   // Counts wrap at 32 bits; the program works with differences
   reg [31:0] wheel_count [0:3];
   reg button_pressed;
   integer k;

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (k = 0; k < 4; k = k + 1) begin
            wheel_count[k] <= `HFS_RST_WORD;
         end
         button_pressed <= 1'b0;
      end else begin
         for (k = 0; k < 4; k = k + 1) begin
            if (wheel_edge[k]) begin
               if (wheel_dn[k]) begin
                  wheel_count[k] <= wheel_count[k] - 32'h00000001; // RULE1
               end else begin
                  wheel_count[k] <= wheel_count[k] + 32'h00000001; // RULE1
               end
            end
         end
         button_pressed <= button_lvl; // RULE2
      end
   end

   // ----------------------------------------------------------------
   // Program-written words
   // ----------------------------------------------------------------
   reg [31:0] mult_select;
   reg [31:0] prio_ctrl;

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         mult_select <= `HFS_RST_WORD;
         prio_ctrl <= `HFS_RST_WORD;
         o_line_angle <= `HFS_RST_WORD;
         o_arc_centre_1 <= `HFS_RST_WORD;
         o_arc_centre_2 <= `HFS_RST_WORD;
      end else if (i_wr) begin
         if (i_addr == `HFS_REG_MULT_SELECT) begin
            mult_select <= {5'h00, i_wdata[`HFS_AXIS_BITS-1:0]}; // RULE3
         end else if (i_addr == `HFS_REG_PRIORITY_CTRL) begin
            prio_ctrl <= {3'h0, i_wdata[28:0]};
         end else if (i_addr == `HFS_REG_LINE_ANGLE) begin
            o_line_angle <= i_wdata; // RULE11
         end else if (i_addr == `HFS_REG_ARC_CENTRE_1) begin
            o_arc_centre_1 <= i_wdata; // RULE11
         end else if (i_addr == `HFS_REG_ARC_CENTRE_2) begin
            o_arc_centre_2 <= i_wdata; // RULE11
         end
      end
   end

   // ----------------------------------------------------------------
   // Field decoders for both words
   // ----------------------------------------------------------------
   wire [17:0] mult_fact;
   wire [17:0] prio_fact;
   wire [8:0] prio_sel;
   genvar g;
   generate
      for (g = 0; g < `HFS_AXES; g = g + 1) begin : g_dec
         hfs_field_decode u_mult (
            .i_field(mult_select[3*g+2:3*g]), // RULE3
            .o_factor(mult_fact[2*g+1:2*g]),
            .o_selected()
         );
         hfs_field_decode u_prio (
            .i_field(prio_ctrl[3*g+2:3*g]),
            .o_factor(prio_fact[2*g+1:2*g]),
            .o_selected(prio_sel[g])
         );
      end
   endgenerate

   // Highest-priority axis: lowest index wins
   wire [8:0] prio_axis = prio_sel & (~prio_sel + 9'h001); // RULE9
   wire prio_active = (prio_ctrl != `HFS_RST_WORD);
   wire prio_enable = prio_ctrl[`HFS_ENABLE_BIT];
   wire general_first = prio_ctrl[`HFS_PRIO_BIT];

   // ----------------------------------------------------------------
   // Mode and factor application
   // ----------------------------------------------------------------
   reg switch_wheel_d;
   reg [17:0] next_factor;
   integer a;

   always @* begin
      next_factor = o_axis_factor;
      for (a = 0; a < `HFS_AXES; a = a + 1) begin
         if (prio_active && prio_axis[a]) begin
            next_factor[2*a+:2] = (prio_fact[2*a+:2] == `HFS_FACT_PANEL) ?
               i_panel_factor : prio_fact[2*a+:2];
         end else if (i_switch_wheel && !switch_wheel_d) begin
            // Sampled only on entry to a handwheel position
            next_factor[2*a+:2] = (mult_fact[2*a+:2] == `HFS_FACT_PANEL) ?
               i_panel_factor : mult_fact[2*a+:2]; // RULE6 RULE4
         end
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         switch_wheel_d <= 1'b0;
         o_wheel_mode <= 1'b0;
         o_axis_factor <= 18'h00000;
      end else begin
         switch_wheel_d <= i_switch_wheel;
         o_wheel_mode <= prio_active | i_switch_wheel; // RULE10
         o_axis_factor <= next_factor; // RULE6
      end
   end

   // ----------------------------------------------------------------
   // Pulse routing to axes
   // ----------------------------------------------------------------
   reg [8:0] next_step;
   reg [8:0] next_dir;
   integer b;

   always @* begin
      next_step = 9'h000;
      next_dir = 9'h000;
      for (b = 0; b < `HFS_AXES; b = b + 1) begin
         if (prio_enable && prio_axis[b] && prio_edge) begin
            // General pulse; blocked when the individual wheel has precedence
            if (general_first || !indiv_edge[b]) begin
               next_step[b] = 1'b1; // RULE7 RULE8
               next_dir[b] = prio_dn;
            end
         end
         if (indiv_edge[b] && !(general_first && prio_enable && prio_axis[b] && prio_edge)) begin
            next_step[b] = 1'b1; // RULE8
            next_dir[b] = indiv_dn[b];
         end
         if (!o_wheel_mode) begin
            next_step[b] = 1'b0;
         end
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_axis_step <= 9'h000;
         o_axis_dir <= 9'h000;
      end else begin
         o_axis_step <= next_step;
         o_axis_dir <= next_dir;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Registered: data belongs to the address of the previous edge
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= `HFS_RST_WORD;
      end else if (i_addr == `HFS_REG_WHEEL1_COUNT) begin
         o_rdata <= wheel_count[0]; // RULE1
      end else if (i_addr == `HFS_REG_WHEEL2_COUNT) begin
         o_rdata <= wheel_count[1];
      end else if (i_addr == `HFS_REG_WHEEL3_COUNT) begin
         o_rdata <= wheel_count[2];
      end else if (i_addr == `HFS_REG_WHEEL4_COUNT) begin
         o_rdata <= wheel_count[3];
      end else if (i_addr == `HFS_REG_BUTTON) begin
         o_rdata <= {31'h00000000, button_pressed}; // RULE2
      end else if (i_addr == `HFS_REG_MULT_SELECT) begin
         o_rdata <= mult_select;
      end else if (i_addr == `HFS_REG_PRIORITY_CTRL) begin
         o_rdata <= prio_ctrl;
      end else if (i_addr == `HFS_REG_LINE_ANGLE) begin
         o_rdata <= o_line_angle;
      end else if (i_addr == `HFS_REG_ARC_CENTRE_1) begin
         o_rdata <= o_arc_centre_1;
      end else if (i_addr == `HFS_REG_ARC_CENTRE_2) begin
         o_rdata <= o_arc_centre_2;
      end else begin
         o_rdata <= `HFS_RST_WORD;
      end
   end
endmodule // hfs_top

`default_nettype wire

// *** dv/hfs_top_chk.sv ***
// Checker for the handwheel factor select top: register port, mode and step timing.
// Assumes one clock and a synchronous active-high reset; attached by bind.
`timescale 1ns/1ps
`default_nettype none
module hfs_top_chk (
   input wire logic i_clk,           // clock
   input wire logic i_sys_rst,       // reset
   input wire logic i_wr,            // write strobe
   input wire logic [3:0] i_addr,    // register number
   input wire logic [31:0] i_wdata,  // write data
   input wire logic i_axis_button,   // button pin
   input wire logic i_switch_wheel,  // mode switch
   input wire logic [31:0] o_rdata,  // read data
   input wire logic o_wheel_mode,    // mode active
   input wire logic [8:0] o_axis_step, // step pulses
   input wire logic [31:0] o_line_angle // line angle
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_mode_on;
      (i_wr && i_addr == 4'h6 && i_wdata[28:0] != 29'h0) |-> ##[1:3] o_wheel_mode;
   endproperty
   a_mode_on: assert property (p_mode_on) else $error("mode not forced");
   property p_mode_off;
      (i_wr && i_addr == 4'h6 && i_wdata[28:0] == 29'h0) ##1 (!i_switch_wheel && !i_wr)[*2]
         |=> !o_wheel_mode;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("mode not released");
   property p_button;
      ($stable(i_axis_button)[*8] ##0 i_addr == 4'h4) |=> o_rdata == {31'h0, $past(i_axis_button)};
   endproperty
   a_button: assert property (p_button) else $error("button status wrong");
   property p_mult_rb;
      (i_wr && i_addr == 4'h5) ##1 i_addr == 4'h5 |=> o_rdata == ($past(i_wdata, 2) & 32'h07FFFFFF);
   endproperty
   a_mult_rb: assert property (p_mult_rb) else $error("multiplier word wrong");
   property p_prio_rb;
      (i_wr && i_addr == 4'h6) ##1 i_addr == 4'h6 |=> o_rdata == ($past(i_wdata, 2) & 32'h1FFFFFFF);
   endproperty
   a_prio_rb: assert property (p_prio_rb) else $error("priority word wrong");
   property p_angle;
      (i_wr && i_addr == 4'h7) |=> o_line_angle == $past(i_wdata);
   endproperty
   a_angle: assert property (p_angle) else $error("line angle not applied");
   property p_no_step;
      !o_wheel_mode [*2] |-> o_axis_step == 9'h0;
   endproperty
   a_no_step: assert property (p_no_step) else $error("step outside mode");
   property p_step_pulse;
      o_axis_step != 9'h0 |=> (o_axis_step & $past(o_axis_step)) == 9'h0;
   endproperty
   a_step_pulse: assert property (p_step_pulse) else $error("step too long");
   c_mode: cover property (o_wheel_mode);
   c_step: cover property (o_axis_step != 9'h0);
   c_rise: cover property ($rose(i_switch_wheel));
endmodule // hfs_top_chk
bind hfs_top hfs_top_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_axis_button(i_axis_button),
   .i_switch_wheel(i_switch_wheel), .o_rdata(o_rdata), .o_wheel_mode(o_wheel_mode),
   .o_axis_step(o_axis_step), .o_line_angle(o_line_angle));
`default_nettype wire

// *** dv/hfs_wheel_model.sv ***
// Handwheel model: four wheels, general wheel and nine individual wheels.
// Assumes the bench calls turn() at a falling edge of the design clock.
`timescale 1ns/1ps
`default_nettype none
module hfs_wheel_model (
   input wire logic i_clk,            // design clock
   output logic [3:0] o_wheel_pulse,  // wheel 1..4 pulses
   output logic o_prio_pulse,         // general wheel pulse
   output logic [8:0] o_indiv_pulse,  // individual wheel pulses
   output logic o_gdir,               // general and wheel 1..4 direction
   output logic o_idir                // individual direction
);
   initial {o_wheel_pulse, o_prio_pulse, o_indiv_pulse, o_gdir, o_idir} = '0;
   // Direction settles a cycle ahead; four high, four low, else pulses get lost
   task automatic turn(input logic [13:0] sel, input logic gdir, input logic idir);
      @(negedge i_clk);
      {o_gdir, o_idir} = {gdir, idir};
      @(negedge i_clk);
      {o_indiv_pulse, o_prio_pulse, o_wheel_pulse} = sel;
      repeat (4) @(negedge i_clk);
      {o_indiv_pulse, o_prio_pulse, o_wheel_pulse} = '0;
      repeat (4) @(negedge i_clk);
   endtask
endmodule // hfs_wheel_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the handwheel factor select top.
// Assumes the wheel model drives the wheel pins; button pin, switch, panel factor and register port driven here.
`timescale 1ns/1ps
`default_nettype none
`include "hfs_map.vh"
module testbench;
   logic clk = 0;
   logic rst = 1;
   logic wr = 0;
   logic btn = 0;
   logic sw = 0;
   logic clr = 0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [1:0] panel = 2'h0;
   logic [8:0] seen = 9'h0;
   logic [8:0] sdir_seen = 9'h0;
   logic [31:0] cnt [4] = '{default: 32'h0};
   int n_mismatch = 0;
   int cmp_count = 0;
   wire [3:0] wp;
   wire pp, gd, id;
   wire [8:0] ip, step, sdir;
   wire [31:0] rdata, ang, c1, c2;
   wire mode;
   wire [17:0] fac;
   always #4 clk = ~clk;
   // Clear requested by the stimulus so seen keeps a single driver
   always @(posedge clk) begin
      if (clr) begin
         seen <= 9'h0;
      end else if (step != 9'h0) begin
         seen <= seen | step;
         sdir_seen <= sdir;
      end
   end
   hfs_wheel_model u_wheel (.i_clk(clk), .o_wheel_pulse(wp), .o_prio_pulse(pp),
      .o_indiv_pulse(ip), .o_gdir(gd), .o_idir(id));
   hfs_top uut (.i_clk(clk), .i_sys_rst(rst), .i_wheel_pulse(wp), .i_wheel_dir({4{gd}}),
      .i_axis_button(btn), .i_prio_pulse(pp), .i_prio_dir(gd), .i_indiv_pulse(ip),
      .i_indiv_dir({9{id}}), .i_switch_wheel(sw), .i_panel_factor(panel), .i_wr(wr),
      .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_wheel_mode(mode),
      .o_axis_factor(fac), .o_axis_step(step), .o_axis_dir(sdir), .o_line_angle(ang),
      .o_arc_centre_1(c1), .o_arc_centre_2(c2));
   function automatic logic [17:0] fexp(input logic [26:0] w, input logic [1:0] p);
      for (int i = 0; i < 9; i++)
         fexp[2*i+:2] = w[3*i] ? 2'h1 : w[3*i+1] ? 2'h2 : w[3*i+2] ? 2'h3 : p;
   endfunction
   function automatic int first_axis(input logic [26:0] w);
      for (int i = 8; i >= 0; i--) if (w[3*i+:3] != 3'h0) first_axis = i;
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Both tasks are entered at a falling edge
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string nm);
      addr = a;
      @(negedge clk);
      chk(nm, exp, rdata);
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      complete_run;
   end
   initial begin
      logic [31:0] w;
      logic [17:0] f;
      logic d;
      int k, ax;
      void'($urandom(70869));
      repeat (3) @(negedge clk);
      rst = 0;
      for (k = 0; k < 6; k++) begin
         w = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h06DB6DB6 : $urandom;
         panel = 2'($urandom);
         wreg(`HFS_REG_MULT_SELECT, w);
         rreg(`HFS_REG_MULT_SELECT, w & 32'h07FFFFFF, "mult");
         sw = 1;
         repeat (2) @(negedge clk);
         chk("factor", 32'(fexp(w[26:0], panel)), 32'(fac));
         wreg(`HFS_REG_MULT_SELECT, ~w);
         @(negedge clk);
         chk("held factor", 32'(fexp(w[26:0], panel)), 32'(fac));
         sw = 0;
         @(negedge clk);
      end
      btn = 1;
      repeat (8) @(negedge clk);
      rreg(`HFS_REG_BUTTON, 32'h1, "button");
      btn = 0;
      for (k = 0; k < 12; k++) begin
         d = 1'($urandom);
         u_wheel.turn(14'(1 << (k % 4)), d, 1'b0);
         cnt[k%4] = d ? cnt[k%4] - 32'h1 : cnt[k%4] + 32'h1;
      end
      repeat (4) @(negedge clk);
      wreg(4'h0, $urandom);
      for (k = 0; k < 4; k++) rreg(4'(k), cnt[k], "count");
      rreg(4'hA, 32'h0, "unmapped");
      rreg(`HFS_REG_BUTTON, 32'h0, "button");
      for (k = 0; k < 6; k++) begin
         w = (k == 0) ? 32'hF4000000 : $urandom | 32'h100;
         ax = first_axis(w[26:0]);
         wreg(`HFS_REG_PRIORITY_CTRL, w);
         rreg(`HFS_REG_PRIORITY_CTRL, w & 32'h1FFFFFFF, "prio word");
         chk("mode", 32'h1, 32'(mode));
         f = fexp(w[26:0], panel);
         chk("prio factor", 32'(f[2*ax+:2]), 32'(fac[2*ax+:2]));
         clr = 1;
         @(negedge clk);
         clr = 0;
         u_wheel.turn(14'h10, k[1], 1'b0);
         repeat (3) @(negedge clk);
         chk("step", 32'(w[28] ? 9'h1 << ax : 9'h0), 32'(seen));
         if (w[28]) chk("dir", 32'(k[1]), 32'(sdir_seen[ax]));
      end
      for (k = 0; k < 2; k++) begin
         wreg(`HFS_REG_PRIORITY_CTRL, {3'h0, 1'b1, k[0], 27'h1});
         clr = 1;
         @(negedge clk);
         clr = 0;
         u_wheel.turn(14'h30, 1'b1, 1'b0);
         repeat (3) @(negedge clk);
         chk("winner step", 32'h1, 32'(seen));
         chk("winner", 32'(k), 32'(sdir_seen[0]));
      end
      wreg(`HFS_REG_PRIORITY_CTRL, 32'h0);
      repeat (3) @(negedge clk);
      chk("mode off", 32'h0, 32'(mode));
      for (k = 7; k < 10; k++) begin
         w = $urandom;
         wreg(4'(k), w);
         @(negedge clk);
         chk("path", w, k == 7 ? ang : k == 8 ? c1 : c2);
      end
      complete_run;
   end
endmodule // testbench
`default_nettype wire
